//--- hw/sadc_pkg.sv
// Constants, field positions and types of the converter control block.
// Assumes a 16-bit register window reached by byte address on a 24-bit bus.
package sadc_pkg;
  localparam int          ADDR_W      = 24;
  localparam int          DATA_W      = 16;
  localparam logic [23:0] BASE_MM1    = 24'hFFF700;
  localparam logic [23:0] BASE_MM0    = 24'h7FF700;
  localparam logic [4:0]  IDX_MCR     = 5'h00;
  localparam logic [4:0]  IDX_TST     = 5'h01;
  localparam logic [4:0]  IDX_PORT    = 5'h03;
  localparam logic [4:0]  IDX_CTL0    = 5'h05;
  localparam logic [4:0]  IDX_CTL1    = 5'h06;
  localparam logic [4:0]  IDX_STAT    = 5'h07;
  localparam logic [1:0]  GRP_RRU     = 2'h1;
  localparam logic [1:0]  GRP_RLS     = 2'h2;
  localparam logic [1:0]  GRP_RLU     = 2'h3;
  localparam int          MCR_STOP    = 15;
  localparam int          MCR_FRZ_LO  = 13;
  localparam int          CTL0_TEN_BIT_RESOLUTION_BIT  = 7;
  localparam int          CTL0_STS_LO = 5;
  localparam int          CTL1_SCAN   = 6;
  localparam int          CTL1_MULT   = 5;
  localparam int          CTL1_S8CM   = 4;
  localparam int          STAT_SCF    = 15;
  localparam int          STAT_BUSY   = 11;
  localparam int          STAT_CDL_LO = 8;
  localparam logic [15:0] MCR_RST     = 16'h8000;
  localparam logic [15:0] CTL0_RST    = 16'h0003;
  localparam logic [15:0] CTL1_RST    = 16'h0000;
  localparam logic [5:0]  PH1_TICKS   = 6'h02;
  localparam logic [5:0]  PH2_TICKS   = 6'h02;
  localparam logic [5:0]  PH3_BASE    = 6'h04;
  localparam logic [3:0]  CH_VRH      = 4'hC;
  localparam logic [3:0]  CH_VRL      = 4'hD;
  localparam logic [3:0]  CH_VMID     = 4'hE;

  typedef enum logic [1:0] {
    FRZ_IGNORE = 2'b00,
    FRZ_RSVD   = 2'b01,
    FRZ_FINISH = 2'b10,
    FRZ_NOW    = 2'b11
  } sadc_frz_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_SAMP1 = 3'b001,
    S_SAMP2 = 3'b010,
    S_SAMP3 = 3'b011,
    S_CONV  = 3'b100
  } sadc_state_t;
endpackage : sadc_pkg

//--- hw/sadc_top.sv
// Converter digital control: register window, sampling sequence, SAR.
// Assumes bus strobes and comparator output are synchronous to mclk.
`timescale 1ns/1ps

// Operation
// RULE1: Decode 32 sixteen-bit words above the base address.
// RULE2: Five control/status words, port word, 24 result words, two reserved.
// RULE3: Base address follows module map bit, normally FFF700.
// RULE4: Buffered registers update at once; control writes abort conversion.
// RULE5: Act as bus slave, terminate cycles, align internal signals.
// RULE6: Results readable in three data formats.
// RULE7: Halt bit idles converter; registers stay reachable.
// RULE8: Setting halt bit aborts a running conversion.
// RULE9: Halt bit set at reset; software clears it before use.
// RULE10: Software waits a recovery interval after clearing halt bit.
// RULE11: Debug response: 00 ignore, 10 finish then halt, 11 halt now.
// RULE12: Debug halt stops converter clock and sequence; registers stay valid.
// RULE13: After debug halt, resume at next step of sequence.
// RULE14: Four-bit channel code picks 16 sources; 0-7 are inputs 0-7.
// RULE15: Codes C, D, E pick high, low, mid reference; rest reserved.
// RULE16: First two converter clocks sample through capacitor to amplifier.
// RULE17: Next two clocks amplifier charges the array, capacitor disconnected.
// RULE18: Third phase charges array directly for sample-time length.
// RULE19: Decide one bit per step from comparator, MSB to LSB.
// RULE20: Resolution is 8 or 10 bits.
// RULE21: Analog pins read as input-only 8-bit port, no direction register.
// RULE22: Sample-time code gives 4, 8, 16 or 32 converter clocks.
// RULE23: Control zero write aborts and halts; control one write restarts.
// RULE24: Reserved debug code behaves as ignore.
module sadc_top
  import sadc_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      srst,
  input  wire logic [sadc_pkg::ADDR_W-1:0] bus_addr,
  input  wire logic [sadc_pkg::DATA_W-1:0] bus_wdata,
  input  wire logic                      bus_wr,
  input  wire logic                      bus_rd,
  output logic      [sadc_pkg::DATA_W-1:0] bus_rdata,
  output logic                           bus_ack,
  input  wire logic                      module_map_bit,
  input  wire logic                      debug_halt,
  input  wire logic                      comparator_high,
  input  wire logic [7:0]                digital_port_inputs,
  output logic      [7:0]                ext_sel,
  output logic                           ref_hi_sel,
  output logic                           ref_lo_sel,
  output logic                           ref_mid_sel,
  output logic                           samp_connect,
  output logic                           amp_charge,
  output logic                           direct_charge,
  output logic      [9:0]                dac_code,
  output logic                           analog_bias_en
);
  import sadc_pkg::*;

  function automatic logic [15:0] fmt(input logic [1:0] grp,
                                      input logic [9:0] v,
                                      input logic       r10);
    logic [15:0] o;
    o = 16'h0000;
    case (grp)
      GRP_RRU: o = r10 ? {6'h00, v} : {8'h00, v[9:2]};
      GRP_RLS: o = {~v[9], v[8:0], 6'h00};
      GRP_RLU: o = {v, 6'h00};
      default: o = 16'h0000;
    endcase
    return o;
  endfunction : fmt

  function automatic logic [11:0] chan_decode(input logic [3:0] c);
    logic [11:0] o;
    o = 12'h000;
    if (!c[3])
      o[c[2:0]] = 1'b1;
    else if (c == CH_VRH)
      o[8] = 1'b1;
    else if (c == CH_VRL)
      o[9] = 1'b1;
    else if (c == CH_VMID)
      o[10] = 1'b1;
    return o;
  endfunction : chan_decode

  logic [15:0] mcr_q;
  logic [15:0] tst_q;
  logic [15:0] ctl0_q;
  logic [15:0] ctl1_q;
  logic [9:0]  rslt_q [8];
  logic [7:0]  ccf_q;
  logic        scf_q;
  logic [15:0] rdata_q;
  logic        ack_q;
  sadc_state_t st_q;
  logic [5:0]  cnt_q;
  logic [2:0]  idx_q;
  logic [3:0]  bit_q;
  logic [9:0]  sar_q;
  logic [5:0]  pre_q;
  logic        tick;
  logic        step;
  logic        frozen;
  logic        hit;
  logic [4:0]  widx;
  logic        wr_hit;
  logic        rd_hit;
  logic        wr_ctl0;
  logic        wr_ctl1;
  logic        abort;
  logic        stop_rise;
  logic [23:0] base;
  logic [5:0]  ph3_len;
  logic [2:0]  last_idx;
  logic        r10;
  logic        conv_done;
  logic [3:0]  chan;
  logic [11:0] sel;
  logic [15:0] stat;
  sadc_frz_t   debug_halt_response;

  // Window decode
  assign base    = module_map_bit ? BASE_MM1 : BASE_MM0; // RULE3
  assign hit     = (bus_addr[23:6] == base[23:6]); // RULE1
  assign widx    = bus_addr[5:1];
  assign wr_hit  = bus_wr & hit;
  assign rd_hit  = bus_rd & hit;
  assign wr_ctl0 = wr_hit & (widx == IDX_CTL0);
  assign wr_ctl1 = wr_hit & (widx == IDX_CTL1);
  assign stop_rise = wr_hit & (widx == IDX_MCR) & bus_wdata[MCR_STOP]
                     & ~mcr_q[MCR_STOP];
  assign abort   = wr_ctl0 | wr_ctl1 | stop_rise; // RULE4 RULE8

  assign debug_halt_response     = sadc_frz_t'(mcr_q[MCR_FRZ_LO+1:MCR_FRZ_LO]);
  assign r10     = ctl0_q[CTL0_TEN_BIT_RESOLUTION_BIT]; // RULE20
  assign ph3_len = PH3_BASE << ctl0_q[CTL0_STS_LO+1:CTL0_STS_LO]; // RULE22
  assign last_idx = ctl1_q[CTL1_S8CM] ? 3'h7 : 3'h3;

  // Debug halt gating
  always_comb
  begin
    case (debug_halt_response)
      FRZ_NOW:    frozen = debug_halt; // RULE11
      FRZ_FINISH: frozen = debug_halt & ((st_q == S_IDLE) |
                           ((st_q == S_SAMP1) & (cnt_q == 6'h00))); // RULE11
      default:    frozen = 1'b0; // RULE24
    endcase
  end

  assign step = tick & ~frozen & ~mcr_q[MCR_STOP]; // RULE7 RULE12
  assign conv_done = step & (st_q == S_CONV) & (bit_q == 4'h0);

  // Converter clock prescaler
  always_ff @(posedge mclk)
  begin
    if (srst)
      pre_q <= 6'h00;
    else if (abort) // RULE16
      pre_q <= 6'h00;
    else if (mcr_q[MCR_STOP] | frozen) // RULE7 RULE12
      pre_q <= pre_q;
    else if (tick)
      pre_q <= 6'h00;
    else
      pre_q <= pre_q + 6'h01;
  end
  assign tick = (pre_q >= {(ctl0_q[4:0] == 5'h00) ? 5'h01 : ctl0_q[4:0],
                           1'b1});

  // Buffered registers
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      mcr_q <= MCR_RST; // RULE9
      tst_q <= 16'h0000;
    end
    else if (wr_hit & (widx == IDX_MCR))
      mcr_q <= bus_wdata & 16'hE000; // RULE4
    else if (wr_hit & (widx == IDX_TST))
      tst_q <= bus_wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ctl0_q <= CTL0_RST;
      ctl1_q <= CTL1_RST;
    end
    else if (wr_ctl0)
      ctl0_q <= bus_wdata & 16'h00FF;
    else if (wr_ctl1)
      ctl1_q <= bus_wdata & 16'h007F;
  end

  // Sequencer
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st_q  <= S_IDLE;
      cnt_q <= 6'h00;
      idx_q <= 3'h0;
    end
    else if (abort)
    begin
      st_q  <= (wr_ctl1 & ~mcr_q[MCR_STOP]) ? S_SAMP1 : S_IDLE; // RULE23
      cnt_q <= 6'h00;
      idx_q <= 3'h0;
    end
    else if (mcr_q[MCR_STOP])
      st_q <= S_IDLE; // RULE7
    else if (step) // RULE13
    begin
      cnt_q <= cnt_q + 6'h01;
      case (st_q)
        S_SAMP1:
          if (cnt_q == PH1_TICKS - 6'h01) // RULE16
          begin
            st_q  <= S_SAMP2;
            cnt_q <= 6'h00;
          end
        S_SAMP2:
          if (cnt_q == PH2_TICKS - 6'h01) // RULE17
          begin
            st_q  <= S_SAMP3;
            cnt_q <= 6'h00;
          end
        S_SAMP3:
          if (cnt_q == ph3_len - 6'h01) // RULE18
          begin
            st_q  <= S_CONV;
            cnt_q <= 6'h00;
          end
        S_CONV:
          if (bit_q == 4'h0)
          begin
            cnt_q <= 6'h00;
            idx_q <= (idx_q == last_idx) ? 3'h0 : idx_q + 3'h1;
            if ((idx_q == last_idx) & ~ctl1_q[CTL1_SCAN])
              st_q <= S_IDLE;
            else
              st_q <= S_SAMP1;
          end
        default:
          cnt_q <= 6'h00;
      endcase
    end
  end

  // Approximation register
  always_ff @(posedge mclk)
  begin
    if (srst | abort)
    begin
      sar_q <= 10'h000;
      bit_q <= 4'h0;
    end
    else if (step & (st_q == S_SAMP3) & (cnt_q == ph3_len - 6'h01))
    begin
      bit_q <= r10 ? 4'h9 : 4'h7;
      sar_q <= r10 ? 10'h200 : 10'h080; // RULE19
    end
    else if (step & (st_q == S_CONV))
    begin
      sar_q[bit_q] <= comparator_high; // RULE19
      if (bit_q != 4'h0)
      begin
        sar_q[bit_q - 4'h1] <= 1'b1;
        bit_q <= bit_q - 4'h1;
      end
    end
  end

  // Result storage and flags
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 8; i++)
        rslt_q[i] <= 10'h000;
    end
    else if (conv_done & ~abort)
    begin
      if (r10)
        rslt_q[idx_q] <= {sar_q[9:1], comparator_high};
      else
        rslt_q[idx_q] <= {sar_q[7:1], comparator_high, 2'b00}; // RULE20
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst | abort)
    begin
      ccf_q <= 8'h00;
      scf_q <= 1'b0;
    end
    else if (conv_done)
    begin
      ccf_q[idx_q] <= 1'b1;
      if (idx_q == last_idx)
        scf_q <= 1'b1;
    end
  end

  assign stat = {scf_q, 3'b000, (st_q != S_IDLE), idx_q, ccf_q};

  // Read path, one cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rdata_q <= 16'h0000;
      ack_q   <= 1'b0;
    end
    else
    begin
      ack_q   <= wr_hit | rd_hit; // RULE5
      rdata_q <= 16'h0000;
      if (rd_hit)
      begin
        if (widx[4:3] != 2'b00)
          rdata_q <= fmt(widx[4:3], rslt_q[widx[2:0]], r10); // RULE6 RULE2
        else
          case (widx)
            IDX_MCR:  rdata_q <= mcr_q;
            IDX_TST:  rdata_q <= tst_q;
            IDX_PORT: rdata_q <= {8'h00, digital_port_inputs}; // RULE21
            IDX_CTL0: rdata_q <= ctl0_q;
            IDX_CTL1: rdata_q <= ctl1_q;
            IDX_STAT: rdata_q <= stat;
            default:  rdata_q <= 16'h0000; // RULE2
          endcase
      end
    end
  end

  assign bus_rdata = rdata_q;
  assign bus_ack   = ack_q;

  // Analog front end controls
  assign chan = ctl1_q[CTL1_MULT] ? ctl1_q[3:0] + {1'b0, idx_q} : ctl1_q[3:0];
  assign sel  = chan_decode(chan); // RULE14 RULE15
  assign ext_sel       = (st_q == S_IDLE) ? 8'h00 : sel[7:0];
  assign ref_hi_sel    = (st_q != S_IDLE) & sel[8];
  assign ref_lo_sel    = (st_q != S_IDLE) & sel[9];
  assign ref_mid_sel   = (st_q != S_IDLE) & sel[10];
  assign samp_connect  = (st_q == S_SAMP1); // RULE16
  assign amp_charge    = (st_q == S_SAMP2); // RULE17
  assign direct_charge = (st_q == S_SAMP3); // RULE18
  assign dac_code      = r10 ? sar_q : {sar_q[7:0], 2'b00}; // RULE20
  assign analog_bias_en = ~mcr_q[MCR_STOP]; // RULE10

  // Checks
  a_stop_at_reset: assert property (@(posedge mclk) // RULE9
    srst |=> mcr_q[MCR_STOP] && st_q == S_IDLE)
    else $error("halt bit not set after reset");

  a_stop_idles: assert property (@(posedge mclk) disable iff (srst) // RULE7
    mcr_q[MCR_STOP] && !wr_hit |=> st_q == S_IDLE && $stable(pre_q))
    else $error("converter active while halted");

  a_ctl0_halts: assert property (@(posedge mclk) disable iff (srst) // RULE23
    wr_ctl0 |=> st_q == S_IDLE && !scf_q && ccf_q == 8'h00)
    else $error("control zero write did not abort");

  a_ctl1_starts: assert property (@(posedge mclk) disable iff (srst) // RULE23
    wr_ctl1 && !mcr_q[MCR_STOP] |=> st_q == S_SAMP1 && cnt_q == 6'h00)
    else $error("control one write did not restart");

  a_freeze_holds: assert property (@(posedge mclk) disable iff (srst) // RULE12
    debug_halt && debug_halt_response == FRZ_NOW && !abort
      |=> $stable(st_q) && $stable(cnt_q) && $stable(sar_q))
    else $error("sequence moved while frozen");

  a_ignore_codes: assert property (@(posedge mclk) disable iff (srst) // RULE24
    debug_halt_response inside {FRZ_IGNORE, FRZ_RSVD} && tick && !mcr_q[MCR_STOP]
      |-> step)
    else $error("debug halt not ignored");

  a_phase_one: assert property (@(posedge mclk) disable iff (srst) // RULE16
    st_q == S_SAMP1 && step && cnt_q == 6'h01 && !abort |=> amp_charge)
    else $error("first sample phase length wrong");

  a_phase_three: assert property (@(posedge mclk) disable iff (srst) // RULE22
    direct_charge && step && !abort && cnt_q == ph3_len - 6'h01
      |=> st_q == S_CONV && sar_q == (r10 ? 10'h200 : 10'h080))
    else $error("third sample phase or msb start wrong");

  a_port_read: assert property (@(posedge mclk) disable iff (srst) // RULE21
    rd_hit && widx == IDX_PORT
      |=> bus_rdata == {8'h00, $past(digital_port_inputs)} && bus_ack)
    else $error("port read data wrong");

endmodule : sadc_top

//--- testbench/sadc_analog_model.sv
// Comparator side of the converter, seen from the SAR logic.
// Assumes the trial code settles within one mclk cycle.
`timescale 1ns/1ps
module sadc_analog_model
  import sadc_pkg::*;
(
  input  wire logic [9:0] dac_code,
  input  wire logic [9:0] vin,
  output logic            comparator_high
);
  // High keeps the trial bit
  assign comparator_high = (dac_code <= vin);
endmodule : sadc_analog_model

//--- testbench/sadc_tb.sv
// Bench for the converter control block: window, sequence, freeze, abort.
// Assumes the analog model holds a fixed input level.
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  import sadc_pkg::*;
  typedef struct packed {
    logic        mm;
    logic [23:0] a;
    logic        w;
    logic [15:0] d;
    logic [15:0] e;
    logic        k;
  } sadc_row_t;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic        module_map_bit = 1'b1;
  logic        debug_halt = 1'b0;
  logic [23:0] bus_addr = 24'h000000;
  logic [15:0] bus_wdata = 16'h0000;
  logic [7:0]  digital_port_inputs = 8'h5A;
  logic [9:0]  vin = 10'h2B5;
  logic [15:0] bus_rdata, rv;
  logic [7:0]  ext_sel;
  logic [9:0]  dac_code;
  logic        bus_ack, ref_hi_sel, ref_lo_sel, ref_mid_sel, kv;
  logic        samp_connect, amp_charge, direct_charge;
  logic        analog_bias_en, comparator_high;
  int          err_total = 0, n_tests = 0, cyc = 0;
  int          n1 = 0, n2 = 0, n3 = 0, b1, b2, b3;
  sadc_row_t   rows [7] = '{
    '{1'b1, 24'hFFF702, 1'b1, 16'hA5C3, 16'hA5C3, 1'b1},
    '{1'b1, 24'hFFF704, 1'b1, 16'hFFFF, 16'h0000, 1'b1},
    '{1'b1, 24'hFFF708, 1'b1, 16'hFFFF, 16'h0000, 1'b1},
    '{1'b1, 24'hFFF706, 1'b0, 16'h0000, 16'h005A, 1'b1},
    '{1'b1, 24'hFFF740, 1'b1, 16'h1234, 16'h0000, 1'b0},
    '{1'b0, 24'h7FF703, 1'b0, 16'h0000, 16'hA5C3, 1'b1},
    '{1'b0, 24'hFFF702, 1'b0, 16'h0000, 16'h0000, 1'b0}};

  always #5 mclk = ~mclk;

  sadc_top dut (.mclk, .srst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata, .bus_ack, .module_map_bit, .debug_halt, .comparator_high,
    .digital_port_inputs, .ext_sel, .ref_hi_sel, .ref_lo_sel, .ref_mid_sel,
    .samp_connect, .amp_charge, .direct_charge, .dac_code, .analog_bias_en);
  sadc_analog_model cmp (.dac_code, .vin, .comparator_high);

  // Phase occupancy counters and run limit
  always @(posedge mclk)
  begin
    cyc++;
    n1 += samp_connect;
    n2 += amp_charge;
    n3 += direct_charge;
    if (cyc == 60000)
    begin
      err_total++;
      final_report();
    end
  end

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [23:0] a);
    @(posedge mclk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1;
    rv = bus_rdata;
    kv = bus_ack;
  endtask : rd

  task automatic wait_scf();
    for (int i = 0; i < 2000; i++)
    begin
      rd(24'hFFF70E);
      if (rv[STAT_SCF] === 1'b1)
        return;
    end
    `CHK("scf", 1'b1, 1'b0)
  endtask : wait_scf

  task automatic wait_dc();
    for (int i = 0; i < 500 && direct_charge !== 1'b1; i++)
    begin
      @(posedge mclk);
      #1;
    end
  endtask : wait_dc

  // Four conversions on input 3, prescale 1: four mclk per tick
  task automatic conv(input logic r, input logic [1:0] s);
    logic [15:0] lj;
    lj = r ? {vin, 6'h00} : {vin[9:2], 8'h00};
    wr(24'hFFF70A, {8'h00, r, s, 5'h01});
    b1 = n1;
    b2 = n2;
    b3 = n3;
    wr(24'hFFF70C, 16'h0003);
    wait_scf();
    `CHK("ph1", 32, n1 - b1)
    `CHK("ph2", 32, n2 - b2)
    `CHK("ph3", 64 << s, n3 - b3)
    rd(24'hFFF710);
    `CHK("rj", r ? {6'h00, vin} : {8'h00, vin[9:2]}, rv)
    rd(24'hFFF720);
    `CHK("ls", lj ^ 16'h8000, rv)
    rd(24'hFFF730);
    `CHK("lu", lj, rv)
  endtask : conv

  initial
  begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    rd(24'hFFF700);
    `CHK("mcr", MCR_RST, rv)
    rd(24'hFFF70A);
    `CHK("ctl0", CTL0_RST, rv)
    rd(24'hFFF70C);
    `CHK("ctl1", CTL1_RST, rv)
    `CHK("bias", 1'b0, analog_bias_en)
    foreach (rows[i])
    begin
      @(posedge mclk) module_map_bit <= rows[i].mm;
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      `CHK("rdata", rows[i].e, rv)
      `CHK("ack", rows[i].k, kv)
    end
    @(posedge mclk) module_map_bit <= 1'b1;
    wr(24'hFFF700, 16'h0000);
    repeat (20) @(posedge mclk);
    `CHK("bias on", 1'b1, analog_bias_en)
    for (int i = 0; i < 4; i++)
      conv(1'(i), 2'(i));
    @(posedge mclk) debug_halt <= 1'b1;
    for (int f = 0; f < 2; f++)
    begin
      wr(24'hFFF700, {1'b0, 2'(f), 13'h0000});
      conv(1'b1, 2'b00);
    end
    @(posedge mclk) debug_halt <= 1'b0;
    wr(24'hFFF700, 16'h6000);
    b1 = n1;
    wr(24'hFFF70C, 16'h0003);
    wait_dc();
    @(posedge mclk) debug_halt <= 1'b1;
    repeat (40) @(posedge mclk);
    #1;
    rv = {6'h00, dac_code};
    b3 = n3;
    repeat (40) @(posedge mclk);
    #1;
    `CHK("frz dac", rv[9:0], dac_code)
    `CHK("frz ph3", 40, n3 - b3)
    @(posedge mclk) debug_halt <= 1'b0;
    wait_scf();
    `CHK("resume", 32, n1 - b1)
    rd(24'hFFF710);
    `CHK("frz res", 16'h02B5, rv)
    wr(24'hFFF700, 16'h4000);
    wr(24'hFFF70C, 16'h0003);
    wait_dc();
    @(posedge mclk) debug_halt <= 1'b1;
    repeat (200) @(posedge mclk);
    rd(24'hFFF70E);
    `CHK("fin ccf", 8'h01, rv[7:0])
    @(posedge mclk) debug_halt <= 1'b0;
    wait_scf();
    wr(24'hFFF700, 16'h0000);
    for (int c = 0; c < 16; c++)
    begin
      wr(24'hFFF70C, {12'h000, 4'(c)});
      repeat (2) @(posedge mclk);
      #1;
      `CHK("sel", c < 8 ? {8'(1 << c), 3'b000} :
        {8'h00, c == 12, c == 13, c == 14},
        {ext_sel, ref_hi_sel, ref_lo_sel, ref_mid_sel})
    end
    wr(24'hFFF70C, 16'h0034);
    wait_dc();
    `CHK("mult sel", 8'h10, ext_sel)
    wait_scf();
    rd(24'hFFF70E);
    `CHK("s8 ccf", 8'hFF, rv[7:0])
    rd(24'hFFF73E);
    `CHK("rslt7", {vin, 6'h00}, rv)
    wr(24'hFFF70C, 16'h0003);
    wait_dc();
    wr(24'hFFF70A, 16'h0081);
    #1;
    `CHK("abort0", 4'h0,
      {samp_connect, amp_charge, direct_charge, |ext_sel})
    rd(24'hFFF70E);
    `CHK("busy", 1'b0, rv[STAT_BUSY])
    wr(24'hFFF70C, 16'h0003);
    wait_dc();
    wr(24'hFFF700, 16'h8000);
    #1;
    `CHK("stop", 5'h00, {samp_connect, amp_charge, direct_charge,
      |ext_sel, analog_bias_en})
    rd(24'hFFF70C);
    `CHK("stop acc", 16'h0003, rv)
    wr(24'hFFF700, 16'h0000);
    wr(24'hFFF70C, 16'h0003);
    wait_dc();
    @(posedge mclk) srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    #1;
    `CHK("rst idle", 5'h00, {samp_connect, amp_charge, direct_charge,
      |ext_sel, analog_bias_en})
    rd(24'hFFF700);
    `CHK("rst mcr", MCR_RST, rv)
    final_report();
  end
endmodule : tb
